// [pkg/umc_pkg.sv]
`default_nettype none
package umc_pkg;
  // AXI4-Lite byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  // Mode register fields
  localparam int MODE_ENABLE = 15;
  localparam int MODE_SIDL = 13;
  localparam int MODE_IR = 12;
  localparam int MODE_RTS_PIN_MODE = 11;
  localparam int MODE_PINSET_HI = 9;
  localparam int MODE_PINSET_LO = 8;
  localparam int MODE_WAKE = 7;
  localparam int MODE_LOOP = 6;
  localparam int MODE_AUTO_BAUD_ENABLE = 5;
  localparam int MODE_RXINV = 4;
  localparam int MODE_HIGH_SPEED_BAUD_SELECT = 3;
  localparam logic [15:0] MODE_WMASK = 16'hBBFF;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [1:0] PINSET_FULL = 2'h2;
  // Status / mask bits
  localparam int ST_WAKE = 0;
  localparam int ST_AUTO_BAUD_ENABLE = 1;
  localparam int ST_W = 2;
  // Control register bits
  localparam int CTRL_IDLE = 0;
  localparam int CTRL_SLEEP = 1;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam int BAUD_W = 20;
endpackage
`default_nettype wire

// [rtl/umc_mode_control.sv]
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module umc_mode_control (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_tx,
  output logic core_rx,
  output logic core_active,
  input wire logic serial_rx_pin,
  input wire logic clear_to_send_pin,
  output logic serial_tx_pin,
  output logic serial_tx_pin_oe,
  output logic request_to_send_pin_oe,
  output logic clear_to_send_pin_own,
  output logic core_cts,
  output logic irq
);
  logic [1:0] rx_sync_reg, cts_sync_reg;
  logic rx_prev_reg;
  logic [15:0] mode_reg, mode_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [umc_pkg::ST_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [umc_pkg::BAUD_W-1:0] baud_reg, baud_next, cnt_reg, cnt_next;
  logic [3:0] edges_reg, edges_next;
  logic meas_reg, meas_next;
  logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic tx_reg, tx_next, txoe_reg, txoe_next, rtsoe_reg, rtsoe_next;
  logic ctsown_reg, ctsown_next, crx_reg, crx_next, act_reg, act_next;
  logic ccts_reg, ccts_next, irq_reg, irq_next;
  logic awr_reg, awr_next, wr_reg, wr_next, arr_reg, arr_next;
  logic en, run, full_pins, rx_pin, rx_line, wr_fire, wake_ev, ab_done, fall;

  always_comb begin
    en = mode_reg[umc_pkg::MODE_ENABLE];
    run = en && !(mode_reg[umc_pkg::MODE_SIDL] && ctrl_reg[umc_pkg::CTRL_IDLE]);
    full_pins = en && mode_reg[umc_pkg::MODE_PINSET_HI:umc_pkg::MODE_PINSET_LO]
      == umc_pkg::PINSET_FULL;
    rx_pin = rx_sync_reg[1] ^ mode_reg[umc_pkg::MODE_RXINV];
    // Infrared pulses are active high on the line; decoder stretches nothing here
    rx_line = mode_reg[umc_pkg::MODE_LOOP] ? tx_reg : rx_pin;
    fall = rx_prev_reg && !rx_line;
    wake_ev = en && ctrl_reg[umc_pkg::CTRL_SLEEP] && mode_reg[umc_pkg::MODE_WAKE] && fall;
    // Sync 0x55 gives five falling edges; start to last edge spans eight bits
    ab_done = meas_reg && fall && edges_reg == 4'h3;
    wr_fire = aw_reg && w_reg && !bv_reg;
  end

  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    mode_next = mode_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      br_next = 2'b00;
      unique case (awa_reg)
        umc_pkg::ADDR_MODE: mode_next = (wd_reg[15:0] & umc_pkg::MODE_WMASK);
        umc_pkg::ADDR_STATUS: stat_next = stat_reg & ~wd_reg[umc_pkg::ST_W-1:0];
        umc_pkg::ADDR_MASK: mask_next = wd_reg[umc_pkg::ST_W-1:0];
        umc_pkg::ADDR_CTRL: ctrl_next = wd_reg[1:0];
        umc_pkg::ADDR_BAUD: ;
        default: br_next = 2'b10;
      endcase
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = 2'b00;
      unique case (s_axi_araddr)
        umc_pkg::ADDR_MODE: rd_next = {16'h0000, mode_reg};
        umc_pkg::ADDR_STATUS: rd_next = {30'h0000_0000, stat_reg};
        umc_pkg::ADDR_MASK: rd_next = {30'h0000_0000, mask_reg};
        umc_pkg::ADDR_CTRL: rd_next = {30'h0000_0000, ctrl_reg};
        umc_pkg::ADDR_BAUD: rd_next = {12'h000, baud_reg};
        default: begin
          rd_next = 32'h0000_0000;
          rr_next = 2'b10;
        end
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    // Hardware clears win after the software write of the same cycle
    if (wake_ev) mode_next[umc_pkg::MODE_WAKE] = 1'b0;
    if (ab_done) mode_next[umc_pkg::MODE_AUTO_BAUD_ENABLE] = 1'b0;
    if (wake_ev) stat_next[umc_pkg::ST_WAKE] = 1'b1;
    if (ab_done) stat_next[umc_pkg::ST_AUTO_BAUD_ENABLE] = 1'b1;
    // Ready flags registered so the bus sees them straight from flip-flops
    awr_next = !aw_next;
    wr_next = !w_next;
    arr_next = !rv_next;
  end

  always_comb begin
    meas_next = meas_reg;
    edges_next = edges_reg;
    cnt_next = cnt_reg;
    baud_next = baud_reg;
    if (!run || !mode_reg[umc_pkg::MODE_AUTO_BAUD_ENABLE]) begin
      meas_next = 1'b0;
      edges_next = 4'h0;
    end else if (!meas_reg && fall) begin
      meas_next = 1'b1;
      edges_next = 4'h0;
      cnt_next = '0;
    end else if (meas_reg) begin
      cnt_next = cnt_reg + 1'b1;
      if (fall) edges_next = edges_reg + 4'h1;
      if (ab_done) begin
        meas_next = 1'b0;
        baud_next = cnt_reg + 1'b1;
      end
    end
  end

  always_comb begin
    // Infrared encoder inverts idle-high data into active-high pulses while high-speed baud select is clear
    tx_next = (mode_reg[umc_pkg::MODE_IR] && mode_reg[umc_pkg::MODE_HIGH_SPEED_BAUD_SELECT] == 1'b0)
      ? ~core_tx : core_tx;
    if (!run) tx_next = 1'b1;
    txoe_next = en;
    rtsoe_next = full_pins;
    ctsown_next = full_pins;
    ccts_next = full_pins ? cts_sync_reg[1] : 1'b0;
    crx_next = run ? (mode_reg[umc_pkg::MODE_IR] ? ~rx_line : rx_line) : 1'b1;
    act_next = run;
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sync_reg <= 2'b11;
      cts_sync_reg <= 2'b11;
      rx_prev_reg <= 1'b1;
      mode_reg <= umc_pkg::MODE_RESET;
      ctrl_reg <= 2'b00;
      stat_reg <= '0;
      mask_reg <= '0;
      baud_reg <= '0;
      cnt_reg <= '0;
      edges_reg <= 4'h0;
      meas_reg <= 1'b0;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      bv_reg <= 1'b0;
      rv_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      rd_reg <= 32'h0000_0000;
      br_reg <= 2'b00;
      rr_reg <= 2'b00;
      tx_reg <= 1'b1;
      txoe_reg <= 1'b0;
      rtsoe_reg <= 1'b0;
      ctsown_reg <= 1'b0;
      crx_reg <= 1'b1;
      act_reg <= 1'b0;
      ccts_reg <= 1'b0;
      irq_reg <= 1'b0;
      awr_reg <= 1'b1;
      wr_reg <= 1'b1;
      arr_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], serial_rx_pin};
      cts_sync_reg <= {cts_sync_reg[0], clear_to_send_pin};
      rx_prev_reg <= rx_line;
      mode_reg <= mode_next;
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      baud_reg <= baud_next;
      cnt_reg <= cnt_next;
      edges_reg <= edges_next;
      meas_reg <= meas_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      bv_reg <= bv_next;
      rv_reg <= rv_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      br_reg <= br_next;
      rr_reg <= rr_next;
      tx_reg <= tx_next;
      txoe_reg <= txoe_next;
      rtsoe_reg <= rtsoe_next;
      ctsown_reg <= ctsown_next;
      crx_reg <= crx_next;
      act_reg <= act_next;
      ccts_reg <= ccts_next;
      irq_reg <= irq_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      arr_reg <= arr_next;
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign serial_tx_pin = tx_reg;
  assign serial_tx_pin_oe = txoe_reg;
  assign request_to_send_pin_oe = rtsoe_reg;
  assign clear_to_send_pin_own = ctsown_reg;
  assign core_rx = crx_reg;
  assign core_active = act_reg;
  assign core_cts = ccts_reg;
  assign irq = irq_reg;

  a_disabled_pins: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(en) |-> !serial_tx_pin_oe && serial_tx_pin && !core_active)
    else $error("port pins driven while disabled");
  a_idle_halt: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(en && mode_reg[umc_pkg::MODE_SIDL] && ctrl_reg[umc_pkg::CTRL_IDLE])
    |-> !core_active) else $error("port ran in idle with stop-in-idle set");
  a_ir_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(run && !mode_reg[umc_pkg::MODE_IR]) |-> serial_tx_pin == $past(core_tx))
    else $error("transmit altered while infrared off");
  a_pin_claim: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(full_pins) |-> request_to_send_pin_oe && clear_to_send_pin_own)
    else $error("flow pins not claimed in pin-set 10");
  a_wake_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    wake_ev |=> !mode_reg[umc_pkg::MODE_WAKE] && stat_reg[umc_pkg::ST_WAKE])
    else $error("wake bit not cleared on start edge");
  a_auto_baud_enable_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    ab_done |=> !mode_reg[umc_pkg::MODE_AUTO_BAUD_ENABLE] && baud_reg == $past(cnt_reg) + 1'b1)
    else $error("auto-baud did not complete cleanly");
  a_loop_route: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_reg[umc_pkg::MODE_LOOP] && !mode_reg[umc_pkg::MODE_IR] && run
    && $stable(mode_reg) |=> core_rx == $past(tx_reg))
    else $error("loopback did not return transmit");
  a_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
    irq == |(stat_reg & mask_reg)) else $error("interrupt level mismatch");
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk, reset_n, awvalid, wvalid, bready, arvalid, rready, core_tx;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, core_rx, core_active;
  logic rx_line, cts_line, tx_pin, tx_oe, rts_oe, cts_own, core_cts, irq;
  int errors, checks;
  logic [3:0] wstrb;
  localparam logic [31:0] EN = 32'h0000_0001 << umc_pkg::MODE_ENABLE;
  localparam logic [31:0] SIDL = 32'h0000_0001 << umc_pkg::MODE_SIDL;
  localparam logic [31:0] IR = 32'h0000_0001 << umc_pkg::MODE_IR;
  localparam logic [31:0] WAKE = 32'h0000_0001 << umc_pkg::MODE_WAKE;
  localparam logic [31:0] LOOP = 32'h0000_0001 << umc_pkg::MODE_LOOP;
  localparam logic [31:0] ABD = 32'h0000_0001 << umc_pkg::MODE_AUTO_BAUD_ENABLE;
  localparam logic [31:0] PS10 = 32'(umc_pkg::PINSET_FULL) << umc_pkg::MODE_PINSET_LO;

  umc_mode_control uut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_tx(core_tx), .core_rx(core_rx),
    .core_active(core_active), .serial_rx_pin(rx_line), .clear_to_send_pin(cts_line),
    .serial_tx_pin(tx_pin), .serial_tx_pin_oe(tx_oe), .request_to_send_pin_oe(rts_oe),
    .clear_to_send_pin_own(cts_own), .core_cts(core_cts), .irq(irq));
  umc_remote peer (.mclk(mclk), .line(rx_line), .cts(cts_line));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 100) errors++;
  endtask
  task axi_read(input logic [7:0] a);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 100) errors++;
  endtask
  // Covers the input synchronisers and the registered outputs
  task wt;
    repeat (8) @(posedge mclk);
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    report_and_stop;
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    core_tx = 1'b1;
    wstrb = 4'hF;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      axi_read(8'(4 * i));
      chk(rd, 32'h0000_0000);
    end
    chk(32'({tx_oe, rts_oe, cts_own, core_active}), 32'h0000_0000);
    axi_read(8'h14);
    chk(rd, 32'h0000_0000);
    chk(32'(rsp), 32'h0000_0002);
    axi_write(8'h14, 32'h0000_1234);
    chk(32'(rsp), 32'h0000_0002);
    // Mode word lives in the low half; upper strobes left off
    wstrb <= 4'h3;
    axi_write(umc_pkg::ADDR_MODE, 32'h0000_FF57);
    wstrb <= 4'hF;
    axi_read(umc_pkg::ADDR_MODE);
    chk(rd, 32'h0000_BB57);
    $display("test registers done");
    peer.set_cts(1'b0);
    axi_write(umc_pkg::ADDR_MODE, EN | PS10);
    wt;
    chk(32'({tx_oe, rts_oe, cts_own, core_active, core_cts}), 32'h0000_001E);
    peer.set_cts(1'b1);
    wt;
    chk(32'(core_cts), 32'h0000_0001);
    axi_write(umc_pkg::ADDR_MODE, EN);
    wt;
    chk(32'({rts_oe, cts_own, tx_oe, core_cts}), 32'h0000_0002);
    $display("test pin set done");
    axi_write(umc_pkg::ADDR_CTRL, 32'h0000_0001);
    wt;
    chk(32'(core_active), 32'h0000_0001);
    axi_write(umc_pkg::ADDR_MODE, EN | SIDL);
    wt;
    chk(32'(core_active), 32'h0000_0000);
    axi_write(umc_pkg::ADDR_CTRL, 32'h0000_0000);
    wt;
    chk(32'(core_active), 32'h0000_0001);
    $display("test idle done");
    axi_write(umc_pkg::ADDR_MODE, EN | LOOP);
    core_tx <= 1'b0;
    wt;
    chk(32'(core_rx), 32'h0000_0000);
    core_tx <= 1'b1;
    wt;
    chk(32'(core_rx), 32'h0000_0001);
    $display("test loopback done");
    // High-speed baud stays zero while infrared is in use
    axi_write(umc_pkg::ADDR_MODE, EN | IR);
    core_tx <= 1'b0;
    peer.set_line(1'b0);
    wt;
    chk(32'({tx_pin, core_rx}), 32'h0000_0003);
    axi_write(umc_pkg::ADDR_MODE, EN);
    wt;
    chk(32'({tx_pin, core_rx}), 32'h0000_0000);
    core_tx <= 1'b1;
    peer.set_line(1'b1);
    $display("test infrared done");
    axi_write(umc_pkg::ADDR_MASK, 32'h0000_0001);
    axi_write(umc_pkg::ADDR_CTRL, 32'h0000_0002);
    axi_write(umc_pkg::ADDR_MODE, EN | WAKE);
    peer.set_line(1'b0);
    wt;
    chk(32'(irq), 32'h0000_0001);
    axi_read(umc_pkg::ADDR_MODE);
    chk(rd, EN);
    peer.set_line(1'b1);
    axi_write(umc_pkg::ADDR_STATUS, 32'h0000_0001);
    axi_write(umc_pkg::ADDR_CTRL, 32'h0000_0000);
    wt;
    chk(32'(irq), 32'h0000_0000);
    $display("test wake done");
    axi_write(umc_pkg::ADDR_MODE, EN | ABD);
    peer.send_byte(umc_pkg::SYNC_CHAR, 16);
    wt;
    axi_read(umc_pkg::ADDR_BAUD);
    chk(rd, 32'd128);
    axi_read(umc_pkg::ADDR_MODE);
    chk(rd, EN);
    axi_read(umc_pkg::ADDR_STATUS);
    chk(rd, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000);
    axi_write(umc_pkg::ADDR_MASK, 32'h0000_0002);
    wt;
    chk(32'(irq), 32'h0000_0001);
    axi_write(umc_pkg::ADDR_STATUS, 32'h0000_0002);
    wt;
    chk(32'(irq), 32'h0000_0000);
    $display("test auto-baud done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// [verification/umc_remote.sv]
`timescale 1ns/1ns
`default_nettype none
module umc_remote (
  input wire logic mclk,
  output logic line,
  output logic cts
);
  // Idle-high serial line, flow control held high by default
  initial begin
    line = 1'b1;
    cts = 1'b1;
  end
  task set_line(input logic v);
    @(posedge mclk);
    line <= v;
  endtask
  task set_cts(input logic v);
    @(posedge mclk);
    cts <= v;
  endtask
  // One frame: start bit, eight data bits LSB first, one stop bit
  task send_byte(input logic [7:0] b, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      line <= frame[i];
      repeat (bit_cyc) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire
